// file: design/scsm_top.sv
// Purpose: smart card mode of an asynchronous serial unit
// Assumes: txd and rxd tied to one pulled-up line outside; rxd_i synchronous
// Notes:   one state struct, two comb blocks, one flop block
// Behaviour
// - bit rate from clock, 1488, N, n
// - fastest rate at N zero, n zero
// - clock pin runs at 372 times rate
// - setting 1,0,0,0 gives port pin
// - fixed low/high level, or serial clock
// - clock enable acts at once, can cut a pulse short
// - smart card select makes pins serial, high-z
// - clearing buffer-empty starts frame, clears done
// - done flag plus mask requests tx_irq
// - returned error sets flag, err_irq
// - full flag plus mask requests rx_irq
// - overrun or parity error requests err_irq
// - parity error byte still stored
// - transmit end interrupt never raised
// - error signal triggers retransmit after 2 bits
// - receive syncs on start, samples 186th
`default_nettype none
module scsm_top (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // register bus
    input  wire scsm_pkg::scsm_wb_req_s wb_req,
    output var  scsm_pkg::scsm_wb_rsp_s wb_rsp,
    // card line and clock pin
    input  wire logic                  rxd_i,
    output var  scsm_pkg::scsm_pins_s   pins,
    // interrupt requests
    output logic [3:0]                 irq
);
    import scsm_pkg::*;

    scsm_state_s s_r;   // registered state
    scsm_state_s s_nxt; // next state

    // bit reversal for most-significant-first cards
    function automatic logic [7:0] rev8(input logic [7:0] d);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7-i];
        end
        return r;
    endfunction

    // data convention; its own inverse, so used both ways
    function automatic logic [7:0] conv(input logic [7:0] d, input logic bit_order_select,
                                        input logic data_invert);
        logic [7:0] v;
        v = data_invert ? ~d : d;
        return bit_order_select ? rev8(v) : v;
    endfunction

    // half period of the base clock in clk cycles
    function automatic logic [14:0] half_len(input logic [7:0] n, input logic [1:0] cks);
        logic [14:0] b;
        b = {7'h00, n} + 15'h0001;
        return b << {cks, 1'b0};
    endfunction

    // interrupt requests straight from flags and masks
    scsm_irq_s irq_s;
    always_comb begin
        irq_s.tx_irq     = s_r.ctrl[B_TIE] & s_r.stat[B_TX_DONE_FLAG];
        irq_s.rx_irq     = s_r.ctrl[B_RIE] & s_r.stat[B_RX_BUF_FULL_FLAG];
        irq_s.err_irq    = s_r.ctrl[B_RIE] & (s_r.stat[B_ERS] | s_r.stat[B_PER]
                                              | s_r.stat[B_OVERRUN_FLAG]);
        irq_s.tx_end_irq = 1'b0;
        irq = irq_s;
    end

    assign wb_rsp = s_r.rsp;
    assign pins   = s_r.pins;

    // all next-state logic
    always_comb begin
        logic       hit;
        logic       wr;
        logic [7:0] d;
        logic [7:0] rv;
        logic [7:0] clr;
        logic       base;
        logic       smart_card_select;
        logic [7:0] byte_v;
        logic       perr;
        hit    = wb_req.cyc & wb_req.stb;
        wr     = hit & s_r.rsp.ack & wb_req.we & wb_req.sel[0];
        d      = wb_req.dat[7:0];
        rv     = 8'h00;
        clr    = 8'h00;
        base   = 1'b0;
        smart_card_select   = s_r.scmr[B_SMART_CARD_SELECT];
        byte_v = 8'h00;
        perr   = 1'b0;
        s_nxt  = s_r;

        // read mux; unmapped addresses read zero
        case (wb_req.adr)
            A_MODE:  rv = s_r.mode;
            A_RATE:  rv = s_r.rate;
            A_CTRL:  rv = s_r.ctrl;
            A_TXD:   rv = s_r.tdr;
            A_STAT:  rv = s_r.stat;
            A_RXD:   rv = s_r.rdr;
            A_SCMR:  rv = s_r.scmr;
            A_PORT:  rv = s_r.port;
            default: rv = 8'h00;
        endcase

        // one wait state: ack and data one edge after the request
        s_nxt.rsp.ack = hit & ~s_r.rsp.ack;
        if (hit & ~s_r.rsp.ack) begin
            s_nxt.rsp.dat = {24'h000000, rv};
            if (~wb_req.we && wb_req.adr == A_STAT) begin
                s_nxt.seen = s_r.stat & M_STAT; // arm clear for flags seen as 1
            end
        end

        // register writes land at the acknowledging edge
        if (wr) begin
            case (wb_req.adr)
                A_MODE:  s_nxt.mode = d & M_MODE;
                A_RATE:  s_nxt.rate = d;
                A_CTRL:  s_nxt.ctrl = d & M_CTRL;
                A_TXD:   s_nxt.tdr  = d;
                A_STAT: begin
                    clr         = s_r.seen & ~d & M_STAT;
                    s_nxt.stat  = s_r.stat & ~clr;
                    s_nxt.seen  = s_r.seen & ~clr;
                end
                A_SCMR:  s_nxt.scmr = d & M_SCMR;
                A_PORT:  s_nxt.port = d & M_PORT;
                default: s_nxt.mode = s_r.mode;
            endcase
        end

        // baud generator runs free; stopping the pin acts at once and can cut a pulse short
        if (s_r.div >= half_len(s_r.rate, s_r.mode[1:0]) - 15'h0001) begin
            s_nxt.div = 15'h0000;
            s_nxt.sck = ~s_r.sck;
            base      = ~s_r.sck;      // one base clock per full sck period
        end else begin
            s_nxt.div = s_r.div + 15'h0001;
        end

        // transmitter; hardware sets below override software clears above
        case (s_r.tx_st)
            TX_IDLE: begin
                s_nxt.tx_oe = 1'b0;
                if (s_r.ctrl[B_TE] & smart_card_select & ~s_r.stat[B_TX_BUF_EMPTY_FLAG]) begin
                    byte_v           = conv(s_r.tdr, s_r.scmr[B_BIT_ORDER_SELECT], s_r.scmr[B_DATA_INVERT]);
                    s_nxt.tx_sh      = {^byte_v ^ s_r.mode[B_ODD], byte_v, 1'b0};
                    s_nxt.stat[B_TX_BUF_EMPTY_FLAG] = 1'b1;
                    s_nxt.stat[B_TX_DONE_FLAG] = 1'b0;
                    s_nxt.tx_st      = TX_RUN;
                    s_nxt.tx_tick    = 9'h000;
                    s_nxt.tx_etu     = 4'h0;
                    s_nxt.tx_oe      = 1'b1;
                    s_nxt.tx_err     = 1'b0;
                end
            end
            TX_RUN: begin
                if (base) begin
                    if (s_r.tx_tick == ETU_LAST) begin
                        s_nxt.tx_tick = 9'h000;
                        s_nxt.tx_etu  = s_r.tx_etu + 4'h1;
                        case (s_r.tx_etu + 4'h1)
                            ETU_REL: s_nxt.tx_oe = 1'b0;    // back to high-z
                            ETU_CHK: begin
                                s_nxt.tx_err = ~rxd_i;      // card pulls low on error
                                if (~rxd_i) begin
                                    s_nxt.stat[B_ERS] = 1'b1;
                                end
                            end
                            ETU_END: begin
                                if (~s_r.tx_err) begin
                                    s_nxt.stat[B_TX_DONE_FLAG] = 1'b1;
                                    s_nxt.tx_st        = TX_IDLE;
                                end
                            end
                            ETU_RETRY: begin
                                s_nxt.tx_etu = 4'h0;        // same byte again
                                s_nxt.tx_oe  = 1'b1;
                                s_nxt.tx_err = 1'b0;
                            end
                            default: s_nxt.tx_err = s_r.tx_err;
                        endcase
                    end else begin
                        s_nxt.tx_tick = s_r.tx_tick + 9'h001;
                    end
                end
            end
            default: s_nxt.tx_st = TX_IDLE;
        endcase
        if (~s_r.ctrl[B_TE] | ~smart_card_select) begin
            s_nxt.tx_st = TX_IDLE;     // disabling aborts a frame in flight
            s_nxt.tx_oe = 1'b0;
        end

        // receiver
        s_nxt.rx_prev = rxd_i;
        case (s_r.rx_st)
            RX_IDLE: begin
                s_nxt.rx_oe = 1'b0;
                if (s_r.ctrl[B_RX_ON] & smart_card_select & s_r.rx_prev & ~rxd_i) begin
                    s_nxt.rx_st   = RX_RUN;
                    s_nxt.rx_tick = 9'h000;
                    s_nxt.rx_etu  = 4'h0;
                end
            end
            RX_RUN, RX_ESIG: begin
                if (base && s_r.rx_tick == SAMPLE_TICK) begin
                    if (s_r.rx_st == RX_RUN) begin
                        s_nxt.rx_sh[s_r.rx_etu] = rxd_i;
                        if (s_r.rx_etu == 4'h0 && rxd_i) begin
                            s_nxt.rx_st = RX_IDLE;  // glitch, not a start bit
                        end
                        if (s_r.rx_etu == ETU_PAR) begin
                            perr   = ^{rxd_i, s_r.rx_sh[8:1]} ^ s_r.mode[B_ODD];
                            byte_v = conv(s_r.rx_sh[8:1], s_r.scmr[B_BIT_ORDER_SELECT],
                                          s_r.scmr[B_DATA_INVERT]);
                            if (s_r.stat[B_RX_BUF_FULL_FLAG]) begin
                                s_nxt.stat[B_OVERRUN_FLAG] = 1'b1;   // old byte kept
                            end else begin
                                s_nxt.rdr = byte_v;          // stored even on error
                                if (perr) begin
                                    s_nxt.stat[B_PER] = 1'b1;
                                end else begin
                                    s_nxt.stat[B_RX_BUF_FULL_FLAG] = 1'b1;
                                end
                            end
                            s_nxt.rx_st = perr ? RX_ESIG : RX_IDLE;
                        end
                    end else begin
                        // error signal low from 10.5 to 11.5 bits
                        if (s_r.rx_etu == ETU_REL) begin
                            s_nxt.rx_oe = 1'b1;
                        end
                        if (s_r.rx_etu == ETU_CHK) begin
                            s_nxt.rx_oe = 1'b0;
                            s_nxt.rx_st = RX_IDLE;
                        end
                    end
                end
                if (base) begin
                    if (s_r.rx_tick == ETU_LAST) begin
                        s_nxt.rx_tick = 9'h000;
                        s_nxt.rx_etu  = s_r.rx_etu + 4'h1;
                    end else begin
                        s_nxt.rx_tick = s_r.rx_tick + 9'h001;
                    end
                end
            end
            default: s_nxt.rx_st = RX_IDLE;
        endcase
        if (~s_r.ctrl[B_RX_ON] | ~smart_card_select) begin
            s_nxt.rx_st = RX_IDLE;
            s_nxt.rx_oe = 1'b0;
        end

        // data pin: high-z unless a frame bit or error signal is driven
        s_nxt.pins.serial_sel = s_nxt.scmr[B_SMART_CARD_SELECT];
        s_nxt.pins.txd_oe     = s_nxt.scmr[B_SMART_CARD_SELECT] & (s_nxt.tx_oe | s_nxt.rx_oe);
        s_nxt.pins.txd_o      = ~s_nxt.rx_oe & (s_nxt.tx_etu > ETU_PAR ? 1'b1
                                                : s_nxt.tx_sh[s_nxt.tx_etu]);

        // clock pin chosen from the next register values, so it changes at the same edge as the registers
        if (s_nxt.scmr[B_SMART_CARD_SELECT] & s_nxt.ctrl[B_CLOCK_OUTPUT_ENABLE]) begin
            s_nxt.pins.sck_o  = s_nxt.sck;
            s_nxt.pins.sck_oe = 1'b1;
        end else if (s_nxt.scmr[B_SMART_CARD_SELECT] & s_nxt.mode[B_CA]) begin
            s_nxt.pins.sck_o  = s_nxt.ctrl[B_CLOCK_LEVEL_SELECT];
            s_nxt.pins.sck_oe = 1'b1;
        end else begin
            s_nxt.pins.sck_o  = s_nxt.port[0];
            s_nxt.pins.sck_oe = s_nxt.port[1];
        end
    end

    // single state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r      <= '0;
            s_r.rate <= R_RATE;
            s_r.stat <= R_STAT;
            s_r.tx_sh <= 10'h3ff;
            s_r.pins.txd_o <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule // scsm_top
`default_nettype wire

// file: design/scsm_pkg.sv
// Purpose: shared constants and types of the smart card serial unit
// Assumes: classic wishbone slave, 8-bit registers in word slots
// Notes:   bit positions match the register layouts used by software
`default_nettype none
package scsm_pkg;
    // baud generator and frame timing
    localparam int         BRG_DIV     = 1488;      // clk per bit = 1488*2^(2n-1)*(N+1)
    localparam int         ETU_BASE    = 372;       // base clocks per bit
    localparam logic [8:0] ETU_LAST    = 9'(ETU_BASE - 1);
    localparam logic [8:0] SAMPLE_TICK = 9'h0b9;    // 186th base clock, zero based
    localparam logic [3:0] ETU_PAR     = 4'h9;      // parity bit slot
    localparam logic [3:0] ETU_REL     = 4'ha;      // line released / error signal start
    localparam logic [3:0] ETU_CHK     = 4'hb;      // error signal sampled / ended
    localparam logic [3:0] ETU_END     = 4'hc;      // frame done when no error
    localparam logic [3:0] ETU_RETRY   = 4'hd;      // retransmit start, 2 bits after check
    // register byte addresses
    localparam logic [4:0] A_MODE  = 5'h00;
    localparam logic [4:0] A_RATE  = 5'h04;
    localparam logic [4:0] A_CTRL  = 5'h08;
    localparam logic [4:0] A_TXD   = 5'h0c;
    localparam logic [4:0] A_STAT  = 5'h10;
    localparam logic [4:0] A_RXD   = 5'h14;
    localparam logic [4:0] A_SCMR  = 5'h18;
    localparam logic [4:0] A_PORT  = 5'h1c;
    // field positions
    localparam int B_CA = 7, B_ODD = 4;             // mode
    localparam int B_TIE = 7, B_RIE = 6, B_TE = 5, B_RX_ON = 4, B_CLOCK_LEVEL_SELECT = 1, B_CLOCK_OUTPUT_ENABLE = 0;
    localparam int B_TX_BUF_EMPTY_FLAG = 7, B_RX_BUF_FULL_FLAG = 6, B_OVERRUN_FLAG = 5, B_ERS = 4, B_PER = 3, B_TX_DONE_FLAG = 2;
    localparam int B_BIT_ORDER_SELECT = 3, B_DATA_INVERT = 2, B_SMART_CARD_SELECT = 0;
    // writable masks and reset values
    localparam logic [7:0] M_MODE = 8'h93;
    localparam logic [7:0] M_CTRL = 8'hf3;
    localparam logic [7:0] M_STAT = 8'hfc;
    localparam logic [7:0] M_SCMR = 8'h0d;
    localparam logic [7:0] M_PORT = 8'h03;
    localparam logic [7:0] R_RATE = 8'hff;
    localparam logic [7:0] R_STAT = 8'h84;
    // sequencer states
    typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_RUN = 1'b1} scsm_tx_e;
    typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_RUN = 2'b01, RX_ESIG = 2'b10} scsm_rx_e;
    // bus and pin carriers
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [4:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } scsm_wb_req_s;
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } scsm_wb_rsp_s;
    typedef struct packed {
        logic txd_o;
        logic txd_oe;
        logic sck_o;
        logic sck_oe;
        logic serial_sel;
    } scsm_pins_s;
    typedef struct packed {
        logic tx_irq;
        logic rx_irq;
        logic err_irq;
        logic tx_end_irq;
    } scsm_irq_s;
    // complete state of the unit
    typedef struct packed {
        scsm_wb_rsp_s rsp;
        logic [7:0]   mode, rate, ctrl, tdr, stat, rdr, scmr, port, seen;
        logic [14:0]  div;
        logic         sck;
        scsm_tx_e     tx_st;
        logic [8:0]   tx_tick;
        logic [3:0]   tx_etu;
        logic [9:0]   tx_sh;
        logic         tx_oe, tx_err;
        scsm_rx_e     rx_st;
        logic [8:0]   rx_tick;
        logic [3:0]   rx_etu;
        logic [9:0]   rx_sh;
        logic         rx_oe, rx_prev;
        scsm_pins_s   pins;
    } scsm_state_s;
endpackage : scsm_pkg
`default_nettype wire

// file: bench/scsm_top_sva.sv
// Purpose: port checks of the smart card serial unit
// Assumes: bench runs the fastest rate, BIT_CLK clocks a bit
// Notes:   bound to scsm_top from the bench top
`default_nettype none
module scsm_top_sva import scsm_pkg::*; #(
    parameter int BIT_CLK = 744  // clocks per bit
) (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   rst_b,
    // register bus
    input wire scsm_pkg::scsm_wb_req_s wb_req,
    input wire scsm_pkg::scsm_wb_rsp_s wb_rsp,
    // card line and pins
    input wire logic                   rxd_i,
    input wire scsm_pkg::scsm_pins_s   pins,
    // interrupt requests
    input wire logic [3:0]             irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] on_r;   // cycles the data pin is driven
    logic [15:0] off_r;  // cycles released, saturating
    // run lengths of the data pin driver
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            on_r  <= 16'h0000;
            off_r <= 16'hffff;
        end else begin
            on_r  <= pins.txd_oe ? on_r + 16'h0001 : 16'h0000;
            off_r <= pins.txd_oe ? 16'h0000 : (&off_r) ? off_r : off_r + 16'h0001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_bus_req;
        wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    endsequence
    sequence s_ack_once;
        wb_rsp.ack ##1 !wb_rsp.ack;
    endsequence
    chk_ack_answer: assert property (s_bus_req |=> s_ack_once)
        else $error("bus request not answered by one ack pulse");
    chk_read_upper: assert property (wb_rsp.dat[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_no_tx_end: assert property (irq[0] == 1'b0)
        else $error("transmit end request raised");
    chk_pin_release: assert property (!pins.serial_sel |-> !pins.txd_oe)
        else $error("data pin driven while not serial");
    chk_start_low: assert property ($rose(pins.txd_oe) |-> !pins.txd_o)
        else $error("frame did not open low");
    chk_frame_len: assert property (on_r <= 16'(10 * BIT_CLK + 4))
        else $error("data pin driven longer than a frame");
    chk_retry_gap: assert property ($rose(pins.txd_oe) |-> off_r >= 16'(2 * BIT_CLK))
        else $error("drive restarted too soon");
    chk_irq_hold: assert property ((|($past(irq[3:1]) & ~irq[3:1])) |->
        ($past(wb_rsp.ack) || $past(wb_rsp.ack, 2)))
        else $error("request dropped without a bus write");
    chk_txirq_idle: assert property ($rose(irq[3]) |-> !pins.txd_oe)
        else $error("transmit request during a frame");
    chk_rxirq_idle: assert property ($rose(irq[2]) |-> !pins.txd_oe)
        else $error("receive request while driving");
endmodule // scsm_top_sva
`default_nettype wire

// file: bench/scsm_card.sv
// Purpose: behavioural card on the shared pulled-up data line
// Assumes: direct convention, bit length BIT_CLK clocks
// Notes:   one process, the card is half duplex anyway
`default_nettype none
module scsm_card #(
    parameter int BIT_CLK = 744  // clocks per bit
) (
    // clock and shared line
    input  wire logic       clk,
    input  wire logic       line,
    output logic            drive_low,
    // bench commands
    input  wire logic       nack,     // answer frames with error signal
    input  wire logic       go,       // send tx_byte
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_bad,   // flip parity of sent frame
    // observations
    output logic [7:0]      rx_byte,
    output logic [7:0]      rx_cnt,
    output logic [7:0]      tx_cnt,
    output logic            sig_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       prev;  // line level one clock ago
    logic [9:0] sh;    // frame bits, start first
    // serve both directions
    initial begin
        drive_low = 1'b0;
        rx_byte = 8'h00;
        rx_cnt = 8'h00;
        tx_cnt = 8'h00;
        sig_seen = 1'b0;
        prev = 1'b1;
        forever begin
            @(posedge clk);
            if (go) begin
                sh = {^tx_byte ^ tx_bad, tx_byte, 1'b0};
                for (int i = 0; i < 10; i++) begin
                    drive_low <= !sh[i];
                    repeat (BIT_CLK) @(posedge clk);
                end
                drive_low <= 1'b0;
                repeat (BIT_CLK * 3 / 4) @(posedge clk);
                sig_seen = !line;  // answer to parity
                repeat (BIT_CLK * 5 / 4) @(posedge clk);
                tx_cnt++;
            end else if (prev && !line) begin
                repeat (BIT_CLK / 2) @(posedge clk);
                for (int i = 0; i < 10; i++) begin
                    sh[i] = line;
                    repeat (BIT_CLK) @(posedge clk);
                end
                rx_byte = sh[8:1];
                if (nack) begin
                    drive_low <= 1'b1;  // one bit error signal
                    repeat (BIT_CLK) @(posedge clk);
                    drive_low <= 1'b0;
                end
                rx_cnt++;
            end
            prev = line;
        end
    end
endmodule // scsm_card
`default_nettype wire

// file: bench/scsm_tb_top.sv
// Purpose: self-checking bench of the smart card serial unit
// Assumes: rate register 0, prescale 0, so a bit is 744 clocks
// Notes:   random bytes from an lfsr seeded with 21
`default_nettype none
module scsm_tb_top import scsm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int         LIMIT = 100000;  // cycle ceiling
    localparam logic [4:0] RA [6] = '{A_MODE, A_RATE, A_CTRL, A_STAT, A_RXD, 5'h1e};
    localparam logic [7:0] RV [6] = '{8'h00, R_RATE, 8'h00, R_STAT, 8'h00, 8'h00};
    localparam logic [7:0] XI [3] = '{8'h04, 8'h06, 8'h02};  // irq per rx frame
    logic         clk, rst_b, card_low, nack, go, tx_bad, sig_seen, sp;
    scsm_wb_req_s wb_req;
    scsm_wb_rsp_s wb_rsp;
    scsm_pins_s   pins;
    logic [3:0]   irq;
    logic [7:0]   tx_byte, card_rx, card_byte, card_tx, rd, seed, a, xb, rises;
    int           num_errors, n_tests, cycles;
    wire          line;  // pulled-up shared line
    assign line = !((pins.txd_oe && !pins.txd_o) || card_low);
    scsm_top i_scsm_top (.clk(clk), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .rxd_i(line), .pins(pins), .irq(irq));
    scsm_card i_scsm_card (.clk(clk), .line(line), .drive_low(card_low), .nack(nack),
        .go(go), .tx_byte(tx_byte), .tx_bad(tx_bad), .rx_byte(card_byte),
        .rx_cnt(card_rx), .tx_cnt(card_tx), .sig_seen(sig_seen));
    always #20 clk = !clk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // line order of a byte under the inverse convention: inverted, msb first
    function automatic logic [7:0] inv_rev(input logic [7:0] b);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = !b[7-i];
        return r;
    endfunction
    task automatic stop_test();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one classic cycle, held until ack
    task automatic wb(input logic we, input logic [4:0] adr, input logic [7:0] wd);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: {24'h0, wd}};
        @(posedge clk);
        while (wb_rsp.ack !== 1'b1) @(posedge clk);
        rd = wb_rsp.dat[7:0];
        wb_req.cyc <= 1'b0;
        wb_req.stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_flag(input int b);
        do wb(1'b0, A_STAT, 8'h00); while (rd[b] !== 1'b1);
    endtask
    // watchdog against hangs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        clk = 1'b0; rst_b = 1'b0; wb_req = '0; nack = 1'b0; go = 1'b0;
        tx_byte = 8'h00; tx_bad = 1'b0; seed = 8'h15; sp = 1'b0; rises = 8'h00;
        num_errors = 0; n_tests = 0; cycles = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        foreach (RA[i]) begin
            wb(1'b0, RA[i], 8'h00);
            check("reset value", rd, RV[i]);
        end
        wb(1'b1, A_CTRL, 8'h00);
        wb(1'b1, A_MODE, 8'h80);
        wb(1'b1, A_SCMR, 8'h01);
        wb(1'b1, A_RATE, 8'h00);
        check("pins serial", {6'h0, pins.serial_sel, pins.txd_oe}, 8'h02);
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, A_CTRL, {6'h0, k[0], 1'b0});
            repeat (2) @(posedge clk);
            check("clock level", {6'h0, pins.sck_oe, pins.sck_o}, {7'h01, k[0]});
        end
        wb(1'b1, A_CTRL, 8'h00);
        wb(1'b1, A_MODE, 8'h00);
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, A_PORT, {7'h01, k[0]});
            repeat (2) @(posedge clk);
            check("port pin", {6'h0, pins.sck_oe, pins.sck_o}, {7'h01, k[0]});
        end
        wb(1'b1, A_MODE, 8'h80);
        wb(1'b1, A_CTRL, 8'h01);
        repeat (ETU_BASE) begin
            @(posedge clk);
            if (pins.sck_o === 1'b1 && sp === 1'b0) rises++;
            sp = pins.sck_o;
        end
        check("clock rises", rises, 8'(ETU_BASE / 2));
        // N = 1, n = 1: align to one rise, then count clocks to the next
        wb(1'b1, A_RATE, 8'h01);
        wb(1'b1, A_MODE, 8'h81);
        for (int k = 0; k < 2; k++) begin
            a = 8'h00;
            do begin
                sp = pins.sck_o;
                @(posedge clk);
                a++;
            end while (!(pins.sck_o === 1'b1 && sp === 1'b0));
        end
        check("clock period", a, 8'(BRG_DIV * 2 * 2 / ETU_BASE));
        wb(1'b1, A_RATE, 8'h00);
        wb(1'b1, A_MODE, 8'h80);
        repeat (2 * BRG_DIV) @(posedge clk);
        wb(1'b1, A_CTRL, 8'he1);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            if (k == 2) wb(1'b1, A_SCMR, 8'h0d);  // inverse convention frame
            wb(1'b0, A_STAT, 8'h00);
            check("status idle", rd & 8'h14, 8'h04);
            nack <= k[0];
            a = card_rx;
            wb(1'b1, A_TXD, seed);
            wb(1'b1, A_STAT, 8'h7f);
            wb(1'b0, A_STAT, 8'h00);
            check("done cleared", rd & 8'h84, 8'h80);
            while (card_rx === a) @(posedge clk);
            check("card byte", card_byte, k == 2 ? inv_rev(seed) : seed);
            if (k == 1) begin
                wait_flag(B_ERS);
                check("error irq", {4'h0, irq}, 8'h02);
                nack <= 1'b0;
                a = card_rx;
                wb(1'b1, A_STAT, 8'hef);
                while (card_rx === a) @(posedge clk);
                check("resent byte", card_byte, seed);
            end
            wait_flag(B_TX_DONE_FLAG);
            check("done irq", {4'h0, irq}, 8'h08);
        end
        wb(1'b1, A_CTRL, 8'h01);
        wb(1'b1, A_SCMR, 8'h01);  // back to direct convention for the card
        wb(1'b1, A_CTRL, 8'h51);
        for (int k = 0; k < 3; k++) begin
            a = card_tx;
            seed = lfsr(seed);
            tx_byte <= seed;
            tx_bad <= (k == 2);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            if (k != 1) xb = seed;
            wait_flag(k == 0 ? B_RX_BUF_FULL_FLAG : k == 1 ? B_OVERRUN_FLAG : B_PER);
            while (card_tx === a) @(posedge clk);
            check("error signal", {7'h0, sig_seen}, {7'h0, k == 2});
            check("rx irq", {4'h0, irq}, XI[k]);
            wb(1'b0, A_RXD, 8'h00);
            check("rx byte", rd, xb);
            if (k == 1) wb(1'b1, A_STAT, 8'h9f);
        end
        stop_test();
    end
endmodule // scsm_tb_top
bind scsm_top scsm_top_sva i_scsm_top_sva (.clk(clk), .rst_b(rst_b), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .rxd_i(rxd_i), .pins(pins), .irq(irq));
`default_nettype wire
